/* File: sfc_pkg.sv */
// sfc_pkg: shared constants for the sensor front-end control link
// assumes: both ends and the testbench import this package
package sfc_pkg;
  localparam int WORD_BITS      = 11;
  localparam int ADDR_BITS      = 3;
  localparam int DATA_BITS      = 8;
  localparam int RESULT_BITS    = 12;
  localparam int GAIN_BITS      = 6;
  localparam int GAIN_POS       = 2;
  localparam int LAT_CLK_00_11  = 8;
  localparam int LAT_PIX_01_10  = 6;
  localparam int CHANNELS       = 3;
  localparam int OFFS_RANGE_POS = 5;
  localparam int CFG_MODE_POS   = 0;
  localparam int CLK_DIV        = 4;
  localparam logic [2:0] REG_RED_GAIN = 3'h0;
  localparam logic [2:0] REG_RED_OFFS = 3'h1;
  localparam logic [2:0] REG_GRN_GAIN = 3'h2;
  localparam logic [2:0] REG_GRN_OFFS = 3'h3;
  localparam logic [2:0] REG_BLU_GAIN = 3'h4;
  localparam logic [2:0] REG_BLU_OFFS = 3'h5;
  localparam logic [2:0] REG_CONFIG   = 3'h6;
  localparam logic [2:0] REG_MODE     = 3'h7;
  localparam logic [7:0] GAIN_RESET   = 8'h00;
  localparam logic [7:0] OFFS_RESET   = 8'h40;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  typedef enum logic [1:0] {SFC_RED, SFC_GRN, SFC_BLU} sfc_color_t;
  function automatic sfc_color_t sfc_next_color(input sfc_color_t c);
    unique case (c)
      SFC_RED: sfc_next_color = SFC_GRN;
      SFC_GRN: sfc_next_color = SFC_BLU;
      SFC_BLU: sfc_next_color = SFC_RED;
      default: sfc_next_color = SFC_RED;
    endcase
  endfunction : sfc_next_color
endpackage : sfc_pkg

/* File: sfc_link_if.sv */
// sfc_link_if: pins between controller and front end
// assumes: the testbench resolves the shared bus from the enables
`timescale 1ns/100ps
interface sfc_link_if;
  logic       conversion_clock;
  logic       line_sync;
  logic       clamp;
  logic [7:0] dev_bus_o;
  logic [7:0] dev_bus_oe_n;
  logic [7:0] ctl_bus_o;
  logic [7:0] ctl_bus_oe_n;
  logic [7:0] bus_level;
  modport dev (input conversion_clock, line_sync, clamp, bus_level,
               output dev_bus_o, dev_bus_oe_n);
  modport ctl (output conversion_clock, line_sync, clamp, ctl_bus_o, ctl_bus_oe_n,
               input bus_level);
endinterface : sfc_link_if

/* File: sfc_device.sv */
// sfc_device: front-end control logic (serial load, colour mux, output bus)
// assumes: link pins are asynchronous and sampled twice on clock_in;
// conversion results arrive on sample_data_in when sample_req_out pulses
`timescale 1ns/100ps
// Overview of operation
// - controller raises clamp during shielded pixels
// - gain/offset follow current colour channel
// - falling edge upper byte, rising lower
// - every third fall samples all colours
// - clock high tracks, low holds/converts
// - clamp high clamps, low tracks inputs
// - sync high: red, bus tristated
// - sync low: next colour each fall
// - 8-bit offset, range bit selects span
// - external reference only after mode write
// - 6-bit gain code, linear one to ten
// - twelve bits as 6+6 or 8+4
// - latency 8 clocks or 6 pixels
// - sync high: pins become serial inputs
// - controller drops load, shifts, raises load
// - bits on serial rise, commit on load rise
// - short load changes nothing
// - clocks past eleventh ignored
// - three address bits, eight data bits
// - power-up defaults per channel
module sfc_device (
  input  wire logic                           clock_in,
  input  wire logic                           srst_in,
  sfc_link_if.dev                             link,
  input  wire logic [sfc_pkg::RESULT_BITS-1:0] sample_data_in,
  output logic                                sample_req_out,
  output logic                                track_out,
  output logic                                clamp_en_out,
  output logic                                input_track_en_out,
  output logic [1:0]                          color_out,
  output logic [sfc_pkg::GAIN_BITS-1:0]       gain_out,
  output logic [sfc_pkg::DATA_BITS-1:0]       offset_out,
  output logic                                offset_sym_out,
  output logic                                ext_ref_en_out,
  output logic [1:0]                          config_out
);
  import sfc_pkg::*;

  logic [4:0] clk_s_q, sync_s_q, clamp_s_q, sck_s_q, sda_s_q, ld_s_q;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      clk_s_q <= '0; sync_s_q <= '0; clamp_s_q <= '0;
      sck_s_q <= '0; sda_s_q <= '0; ld_s_q <= 5'h1F;
    end else begin
      clk_s_q   <= {clk_s_q[3:0], link.conversion_clock};
      sync_s_q  <= {sync_s_q[3:0], link.line_sync};
      clamp_s_q <= {clamp_s_q[3:0], link.clamp};
      sck_s_q   <= {sck_s_q[3:0], link.bus_level[5]};
      sda_s_q   <= {sda_s_q[3:0], link.bus_level[6]};
      ld_s_q    <= {ld_s_q[3:0], link.bus_level[7]};
    end
  end
  // stage 1 is sync stage two; edges compare stages 1 and 2
  wire cclk     = clk_s_q[1];
  wire cclk_fall = clk_s_q[2] & ~clk_s_q[1];
  wire cclk_rise = ~clk_s_q[2] & clk_s_q[1];
  wire sync_hi  = sync_s_q[1];
  wire sck_rise = ~sck_s_q[2] & sck_s_q[1];
  wire sda      = sda_s_q[1];
  wire ld       = ld_s_q[1];
  wire ld_fall  = ld_s_q[2] & ~ld_s_q[1];
  wire ld_rise  = ~ld_s_q[2] & ld_s_q[1];

  // serial load engine
  logic [WORD_BITS-1:0] shift_q, shift_d;
  logic [3:0]           cnt_q, cnt_d;
  logic [DATA_BITS-1:0] regs_q [8];
  wire in_load = sync_hi & ~ld;
  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    if (!sync_hi || ld_fall) begin
      cnt_d = 4'h0;
    end else if (in_load && sck_rise && cnt_q < 4'(WORD_BITS)) begin
      shift_d = {shift_q[WORD_BITS-2:0], sda};
      cnt_d   = cnt_q + 4'h1;
    end
  end
  // serial only while sync high; ignored otherwise
  // commit on load rise; only with full word
  wire commit = sync_hi & ld_rise & (cnt_q == 4'(WORD_BITS));
  wire [ADDR_BITS-1:0] waddr = shift_q[WORD_BITS-1 -: ADDR_BITS];
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      shift_q <= '0;
      cnt_q   <= '0;
      regs_q[REG_RED_GAIN] <= GAIN_RESET; regs_q[REG_RED_OFFS] <= OFFS_RESET;
      regs_q[REG_GRN_GAIN] <= GAIN_RESET; regs_q[REG_GRN_OFFS] <= OFFS_RESET;
      regs_q[REG_BLU_GAIN] <= GAIN_RESET; regs_q[REG_BLU_OFFS] <= OFFS_RESET;
      regs_q[REG_CONFIG]   <= CONFIG_RESET; regs_q[REG_MODE] <= MODE_RESET;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      if (commit)
        regs_q[waddr] <= shift_q[DATA_BITS-1:0];
    end
  end

  // colour multiplexer
  sfc_color_t color_q;
  logic [1:0] phase_q;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      color_q <= SFC_RED;
      phase_q <= 2'h0;
    end else if (sync_hi) begin
      color_q <= SFC_RED;
      phase_q <= 2'h0;
    end else if (cclk_fall) begin
      color_q <= sfc_next_color(color_q);
      phase_q <= (phase_q == 2'(CHANNELS-1)) ? 2'h0 : phase_q + 2'h1;
    end
  end
  wire [1:0] cfg_mode = regs_q[REG_CONFIG][CFG_MODE_POS +: 2];
  wire       triple   = (cfg_mode == 2'b01) | (cfg_mode == 2'b10);
  // triple mode samples on every third fall
  wire sample_now = cclk_fall & ~sync_hi & (~triple | (phase_q == 2'h0));

  // result pipeline: latency in falls depends on mode
  localparam int PIPE = LAT_CLK_00_11;
  logic [RESULT_BITS-1:0] pipe_q [PIPE];
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < PIPE; i++) pipe_q[i] <= '0;
    end else if (cclk_fall) begin
      pipe_q[0] <= sample_data_in;
      for (int i = 1; i < PIPE; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  wire [RESULT_BITS-1:0] result =
    triple ? pipe_q[LAT_PIX_01_10-1] : pipe_q[LAT_CLK_00_11-1];
  wire fmt_84 = regs_q[REG_MODE][1];
  wire [7:0] hi_byte = fmt_84 ? result[11:4] : {result[11:6], 2'b00};
  wire [7:0] lo_byte = fmt_84 ? {result[3:0], 4'h0} : {result[5:0], 2'b00};

  wire [2:0] gsel = {color_q, 1'b0};
  wire [2:0] osel = {color_q, 1'b1};

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      link.dev_bus_o     <= '0;
      link.dev_bus_oe_n  <= 8'hFF;
      sample_req_out     <= 1'b0;
      track_out          <= 1'b0;
      clamp_en_out       <= 1'b0;
      input_track_en_out <= 1'b0;
      color_out          <= 2'h0;
      gain_out           <= '0;
      offset_out         <= OFFS_RESET;
      offset_sym_out     <= 1'b0;
      ext_ref_en_out     <= 1'b0;
      config_out         <= 2'h0;
    end else begin
      if (sync_hi)
        link.dev_bus_oe_n <= 8'hFF;
      else if (cclk_fall) begin
        link.dev_bus_oe_n <= 8'h00;
        link.dev_bus_o    <= hi_byte;
      end else if (cclk_rise)
        link.dev_bus_o    <= lo_byte;
      sample_req_out     <= sample_now;
      track_out          <= cclk;
      clamp_en_out       <= clamp_s_q[1];
      input_track_en_out <= ~clamp_s_q[1];
      color_out          <= color_q;
      gain_out           <= regs_q[gsel][DATA_BITS-1 -: GAIN_BITS];
      offset_out         <= regs_q[osel];
      offset_sym_out     <= regs_q[REG_CONFIG][OFFS_RANGE_POS];
      ext_ref_en_out     <= regs_q[REG_MODE][0];
      config_out         <= cfg_mode;
    end
  end
endmodule : sfc_device

/* File: sfc_controller.sv */
// sfc_controller: scanner-side driver of clocks, sync, clamp and serial load
// assumes: user issues writes while idle; results collected by the user
`timescale 1ns/100ps
module sfc_controller (
  input  wire logic                            clock_in,
  input  wire logic                            srst_in,
  sfc_link_if.ctl                              link,
  input  wire logic                            run_in,
  input  wire logic                            clamp_req_in,
  input  wire logic                            wr_req_in,
  input  wire logic [sfc_pkg::ADDR_BITS-1:0]  wr_addr_in,
  input  wire logic [sfc_pkg::DATA_BITS-1:0]  wr_data_in,
  output logic                                 wr_busy_out,
  output logic [15:0]                          pixel_out,
  output logic                                 pixel_valid_out
);
  import sfc_pkg::*;

  logic [3:0]             div_q, bit_q;
  logic                   cclk_q, sync_q, clamp_q, sck_q, sda_q, ld_q, lo_phase_q;
  logic [WORD_BITS-1:0]   word_q;
  logic [7:0]             hi_q, bus1_q, bus2_q;
  logic [2:0]             st_q;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      div_q <= '0; cclk_q <= 1'b1; sync_q <= 1'b1; clamp_q <= 1'b0;
      sck_q <= 1'b0; sda_q <= 1'b0; ld_q <= 1'b1; bit_q <= '0;
      word_q <= '0; st_q <= '0; wr_busy_out <= 1'b0;
      hi_q <= '0; bus1_q <= '0; bus2_q <= '0; lo_phase_q <= 1'b0;
      pixel_out <= '0; pixel_valid_out <= 1'b0;
    end else begin
      bus1_q <= link.bus_level;
      bus2_q <= bus1_q;
      div_q <= (div_q == 4'(CLK_DIV-1)) ? 4'h0 : div_q + 4'h1;
      pixel_valid_out <= 1'b0;
      // clamp from user during shielded pixels
      clamp_q <= clamp_req_in;
      if (div_q == 4'(CLK_DIV-1)) begin
        if (st_q != 3'h0) begin
          unique case (st_q)
            3'h1: begin ld_q <= 1'b0; st_q <= 3'h2; end
            3'h2: begin
              sck_q <= 1'b0;
              sda_q <= word_q[WORD_BITS-1];
              word_q <= {word_q[WORD_BITS-2:0], 1'b0};
              st_q <= 3'h3;
            end
            3'h3: begin
              sck_q <= 1'b1;
              bit_q <= bit_q + 4'h1;
              st_q  <= (bit_q == 4'(WORD_BITS-1)) ? 3'h4 : 3'h2;
            end
            3'h4: begin sck_q <= 1'b0; st_q <= 3'h5; end
            default: begin ld_q <= 1'b1; st_q <= 3'h0; wr_busy_out <= 1'b0; end
          endcase
        end else if (wr_req_in && !wr_busy_out) begin
          sync_q <= 1'b1; word_q <= {wr_addr_in, wr_data_in};
          bit_q <= '0; st_q <= 3'h1; wr_busy_out <= 1'b1;
        end else begin
          sync_q <= ~run_in;
          cclk_q <= ~cclk_q;
          // demux bytes; caller aligns for latency
          if (!sync_q && cclk_q) hi_q <= bus2_q;
          if (!sync_q && !cclk_q) begin
            pixel_out <= {hi_q, bus2_q};
            pixel_valid_out <= 1'b1;
          end
        end
      end
    end
  end
  // drive serial pins only once the front end has let the bus go
  logic [2:0] guard_q;
  always_ff @(posedge clock_in) begin
    if (srst_in || !sync_q) begin
      guard_q <= 3'h0;
    end else if (guard_q != 3'h4) begin
      guard_q <= guard_q + 3'h1;
    end
  end
  wire pins_driven = sync_q & (guard_q == 3'h4);
  always_comb begin
    link.conversion_clock = cclk_q;
    link.line_sync        = sync_q;
    link.clamp            = clamp_q;
    link.ctl_bus_o        = {ld_q, sda_q, sck_q, 5'h00};
    link.ctl_bus_oe_n     = pins_driven ? 8'h1F : 8'hFF;
  end
endmodule : sfc_controller

/* File: sfc_link_chk.sv */
// sfc_link_chk: concurrent checks on the controller to front-end link
// assumes: instantiated beside the link interface, all in the clock_in domain
`timescale 1ns/100ps
module sfc_link_chk (
  input wire logic       clock_in,
  input wire logic       srst_in,
  input wire logic       line_sync,
  input wire logic [7:0] dev_bus_o,
  input wire logic [7:0] dev_bus_oe_n,
  input wire logic [7:0] ctl_bus_o,
  input wire logic [7:0] ctl_bus_oe_n
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  chk_no_bus_fight: assert property ((dev_bus_oe_n | ctl_bus_oe_n) == 8'hFF)
    else $error("both ends drive the bus");
  chk_sync_tristate: assert property (line_sync [*6] |-> dev_bus_oe_n == 8'hFF)
    else $error("front end drives bus during sync");
  chk_ctl_pin_dir: assert property (!line_sync |-> ctl_bus_oe_n == 8'hFF)
    else $error("controller drives pins outside sync");
  chk_ctl_pin_load: assert property (line_sync [*8] |-> ctl_bus_oe_n == 8'h1F)
    else $error("controller does not drive serial pins");
  chk_sck_phase: assert property (line_sync && $changed(ctl_bus_o[5])
    |=> $stable(ctl_bus_o[5]) [*3])
    else $error("serial clock phase too short");
  chk_sck_in_load: assert property (line_sync && $rose(ctl_bus_o[5]) |-> !ctl_bus_o[7])
    else $error("serial clock outside a load");
  chk_sdata_setup: assert property (line_sync && $rose(ctl_bus_o[5])
    |-> $stable(ctl_bus_o[6]))
    else $error("serial data moves at clock rise");
  chk_drive_after: assert property ($fell(line_sync) |-> ##[1:12] dev_bus_oe_n == 8'h00)
    else $error("front end does not drive bus");
  chk_reset_idle: assert property ($fell(srst_in) |-> line_sync && ctl_bus_o[7])
    else $error("controller not idle after reset");
endmodule : sfc_link_chk

/* File: sensor_frontend_ctrl_serial_tb.sv */
// sensor_frontend_ctrl_serial_tb: controller and front end joined, plus a second
// front end whose serial port the bench drives with full, short, long and sync-low loads
// assumes: sfc_pkg, sfc_link_if, both ends and sfc_link_chk compiled first
`timescale 1ns/100ps
module sensor_frontend_ctrl_serial_tb;
  import sfc_pkg::*;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        run_in = 1'b0;
  logic        wr_req_in = 1'b0;
  logic [2:0]  wr_addr_in = '0;
  logic [7:0]  wr_data_in = '0;
  logic [11:0] sample_data_in = '0;
  logic        wr_busy_out, pixel_valid_out, offset_sym_out, ext_ref_en_out;
  logic        flip = 1'b0;
  logic        mon_en = 1'b0;
  logic        clamp_req = 1'b0;
  logic        track_seen, clamp_seen, itrack_seen;
  logic [2:0]  cc_hist = '0;
  logic [2:0]  cl_hist = '0;
  logic [15:0] pixel_out;
  logic [1:0]  color_out, config_out;
  logic [5:0]  gain_out, gain2;
  logic [7:0]  offset_out, offset2;
  logic [31:0] lfsr = 32'h0279;
  logic [13:0] tab[3];
  logic [15:0] exp_q[$];
  int          n_mismatch = 0;
  int          check_count = 0;
  sfc_link_if  link ();
  sfc_link_if  link2 ();
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) flip <= ~flip;
  // undriven pins toggle so a stale level never passes
  assign link.bus_level = (~link.dev_bus_oe_n & link.dev_bus_o)
    | (link.dev_bus_oe_n & ~link.ctl_bus_oe_n & link.ctl_bus_o)
    | (link.dev_bus_oe_n & link.ctl_bus_oe_n & {8{flip}});
  sfc_controller sfc_controller_i (.clock_in(clock_in), .srst_in(srst_in), .link(link.ctl),
    .run_in(run_in), .clamp_req_in(clamp_req), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .wr_busy_out(wr_busy_out), .pixel_out(pixel_out),
    .pixel_valid_out(pixel_valid_out));
  sfc_device sfc_device_i (.clock_in(clock_in), .srst_in(srst_in), .link(link.dev),
    .sample_data_in(sample_data_in), .sample_req_out(), .track_out(track_seen),
    .clamp_en_out(clamp_seen), .input_track_en_out(itrack_seen), .color_out(color_out),
    .gain_out(gain_out), .offset_out(offset_out),
    .offset_sym_out(offset_sym_out), .ext_ref_en_out(ext_ref_en_out), .config_out(config_out));
  sfc_device sfc_device2_i (.clock_in(clock_in), .srst_in(srst_in), .link(link2.dev),
    .sample_data_in(12'h000), .sample_req_out(), .track_out(), .clamp_en_out(),
    .input_track_en_out(), .color_out(), .gain_out(gain2), .offset_out(offset2),
    .offset_sym_out(), .ext_ref_en_out(), .config_out());
  sfc_link_chk sfc_link_chk_i (.clock_in(clock_in), .srst_in(srst_in),
    .line_sync(link.line_sync), .dev_bus_o(link.dev_bus_o), .dev_bus_oe_n(link.dev_bus_oe_n),
    .ctl_bus_o(link.ctl_bus_o), .ctl_bus_oe_n(link.ctl_bus_oe_n));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic ctl_write(input logic [2:0] a, input logic [7:0] d);
    int k;
    @(negedge clock_in);
    wr_addr_in = a;
    wr_data_in = d;
    wr_req_in = 1'b1;
    for (k = 0; k < 200 && wr_busy_out !== 1'b1; k++) @(negedge clock_in);
    wr_req_in = 1'b0;
    for (k = 0; k < 400 && wr_busy_out !== 1'b0; k++) @(negedge clock_in);
    repeat (8) @(negedge clock_in);
  endtask : ctl_write
  // n serial clocks of 160 ns; bits past eleven carry noise
  task automatic bb_load(input logic [10:0] w, input int n);
    @(negedge clock_in);
    link2.bus_level[7] = 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.bus_level[5] = 1'b0;
      link2.bus_level[6] = (i < 11) ? w[10 - i] : flip;
      repeat (4) @(negedge clock_in);
      link2.bus_level[5] = 1'b1;
      repeat (4) @(negedge clock_in);
    end
    link2.bus_level[7] = 1'b1;
    repeat (10) @(negedge clock_in);
  endtask : bb_load
  task automatic run_frame(input logic [7:0] cfg, input logic [7:0] mode);
    ctl_write(REG_CONFIG, cfg);
    ctl_write(REG_MODE, mode);
    check("cfg", {cfg[5], cfg[1:0], mode[0]}, {offset_sym_out, config_out, ext_ref_en_out});
    lfsr = lfsr_next(lfsr);
    sample_data_in = lfsr[11:0];
    clamp_req = lfsr[16];
    run_in = 1'b1;
    repeat (12) @(posedge pixel_valid_out);
    exp_q.push_back(mode[1] ? {lfsr[11:4], lfsr[3:0], 4'h0} : {lfsr[11:6], 2'b00, lfsr[5:0], 2'b00});
    @(negedge clock_in);
    clamp_req = ~clamp_req;
    repeat (3) @(posedge pixel_valid_out);
    @(negedge clock_in);
    run_in = 1'b0;
    repeat (40) @(negedge clock_in);
    check("sync colour", 2'(SFC_RED), color_out);
  endtask : run_frame
  always @(posedge clock_in) begin
    if (pixel_valid_out === 1'b1 && exp_q.size() > 0) check("pixel", exp_q.pop_front(), pixel_out);
  end
  // link levels reach the front end outputs after two sync stages and a register
  always @(posedge clock_in) begin
    cc_hist <= {cc_hist[1:0], link.conversion_clock};
    cl_hist <= {cl_hist[1:0], link.clamp};
  end
  always @(negedge clock_in) begin
    if (mon_en) check("channel regs", tab[color_out], {gain_out, offset_out});
    if (mon_en) check("track levels", {cl_hist[2], ~cl_hist[2], cc_hist[2]}, {clamp_seen, itrack_seen, track_seen});
  end
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    link2.conversion_clock = 1'b1;
    link2.line_sync = 1'b1;
    link2.clamp = 1'b0;
    link2.bus_level = 8'hFF;
    repeat (12) @(negedge clock_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    check("reset regs", {GAIN_RESET[7:2], OFFS_RESET}, {gain_out, offset_out});
    check("reset mode", {CONFIG_RESET[5], CONFIG_RESET[1:0], MODE_RESET[0], 2'(SFC_RED)},
      {offset_sym_out, config_out, ext_ref_en_out, color_out});
    for (int c = 0; c < 3; c++) begin
      lfsr = lfsr_next(lfsr);
      tab[c] = lfsr[13:0];
      ctl_write(3'(2 * c), {lfsr[13:8], lfsr[15:14]});
      ctl_write(3'(2 * c + 1), lfsr[7:0]);
    end
    check("red regs", tab[0], {gain_out, offset_out});
    mon_en = 1'b1;
    run_frame(8'h21, 8'h01);
    run_frame(8'h00, 8'h02);
    check("tristate", 8'hFF, link2.dev_bus_oe_n);
    bb_load({REG_RED_OFFS, 8'h5A}, 11);
    check("load 11", 8'h5A, offset2);
    bb_load({REG_RED_OFFS, 8'hC3}, 10);
    check("load short", 8'h5A, offset2);
    bb_load({REG_RED_GAIN, 8'hB4}, 13);
    check("load long", 6'h2D, gain2);
    link2.line_sync = 1'b0;
    bb_load({REG_RED_OFFS, 8'h11}, 11);
    check("sync low load", 8'h5A, offset2);
    give_verdict();
  end
endmodule : sensor_frontend_ctrl_serial_tb
